// ### tb/ifx_bus_peer.sv
// far bus device: phase, attention and request lines
// assumes commands from the bench on clk_sys
`timescale 1ns/10ps
`default_nettype none
module ifx_bus_peer (
	// bench control
	input wire logic       clk_sys, atn,
	input wire logic [2:0] ph,
	input wire logic [3:0] reqDly,
	// bus lines
	output wire logic busMsg, busCd, busIo, busSel, busBsy,
	output wire logic bus_request_line, attention_line
);
	logic [3:0] cnt = 4'h0;
	assign {busMsg, busCd, busIo} = ph;
	assign {busSel, busBsy} = 2'h1;
	assign attention_line = atn;
	always @(posedge clk_sys)
		cnt <= reqDly == 4'h0 ? 4'h0 : cnt + {3'h0, cnt != 4'hF};
	assign bus_request_line = reqDly != 4'h0 && cnt >= reqDly;
endmodule // ifx_bus_peer
`default_nettype wire

// ### tb/ifx_exec_monitor.sv
// checker for the no-halt interrupt executor
// sees only executor ports, single clock domain
`timescale 1ns/10ps
`default_nettype none
module ifx_monitor (
	// watched ports
	input wire logic        clk_sys, rst, regWr, regRd,
	input wire logic        hostIrq, instrDone, haltReq,
	input wire logic [3:0]  regAddr,
	input wire logic [31:0] regWrData, regRdData
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	halt_done_a: assert property (haltReq |-> instrDone)
		else $error("halt alone");
	done_pulse_a: assert property (instrDone |=> !instrDone)
		else $error("done long");
	rd_idle_a: assert property (!$past(regRd) |-> regRdData == 32'h0)
		else $error("stray data");
	rd_unmap_a: assert property (regRd && regAddr > 4'h3 |=> !regRdData)
		else $error("unmapped data");
	irq_cause_a: assert property ($rose(hostIrq) |->
		instrDone || $past(regWr, 2)) else $error("irq cause");
	irq_drop_a: assert property ($fell(hostIrq) |-> $past(regWr, 2))
		else $error("irq drop");
	clr_flag_a: assert property (regWr && regAddr == 4'h2 &&
		regWrData[0] ##1 !instrDone ##1 !instrDone |-> !hostIrq)
		else $error("clear");
	mask_off_a: assert property (regWr && regAddr == 4'h3 &&
		!regWrData[0] |=> ##1 !hostIrq) else $error("mask");
endmodule // ifx_monitor
bind ifx_interrupt_no_halt_exec ifx_monitor mon (.clk_sys(clk_sys),
	.rst(rst), .regWr(regWr), .regRd(regRd), .hostIrq(hostIrq),
	.instrDone(instrDone), .haltReq(haltReq), .regAddr(regAddr),
	.regWrData(regWrData), .regRdData(regRdData));
`default_nettype wire

// ### tb/interrupt_on_fly_exec_tb_top.sv
// bench for the no-halt interrupt executor
// assumes peer model and checker compiled first
`timescale 1ns/10ps
`default_nettype none
module interrupt_on_fly_exec_tb_top;
	logic clk_sys = '0, rst = '1, instrValid = '0, initiatorMode = '1;
	logic aluCarry = '0, fetchWrite = '0, regWr = '0, regRd = '0, atn = '0;
	logic [31:0] instrWord = '0, fetchWord = '0, regWrData = '0;
	logic [7:0] last_byte_reg = '0;
	logic [3:0] regAddr = '0, reqDly = '0;
	logic [2:0] ph = '0;
	logic en = '1;
	wire logic [31:0] regRdData;
	wire logic bMsg, bCd, bIo, bSel, bBsy, bReq, bAtn, hostIrq, instrDone, haltReq;
	wire logic bRes;
	int error_cnt = 0, n_compared = 0, lat, i;
	always #50 clk_sys = ~clk_sys;
	ifx_bus_peer peer (.clk_sys(clk_sys), .atn(atn), .ph(ph), .reqDly(reqDly),
		.busMsg(bMsg), .busCd(bCd), .busIo(bIo), .busSel(bSel), .busBsy(bBsy),
		.bus_request_line(bReq), .attention_line(bAtn));
	ifx_interrupt_no_halt_exec uut (.clk_sys(clk_sys), .rst(rst),
		.instrValid(instrValid), .instrWord(instrWord),
		.instrValue(32'hC0DE0001), .initiatorMode(initiatorMode),
		.aluCarry(aluCarry), .last_byte_reg(last_byte_reg),
		.fetchWrite(fetchWrite), .fetchWord(fetchWord), .busMsg(bMsg),
		.busCd(bCd), .busIo(bIo), .busSel(bSel), .busBsy(bBsy),
		.bus_request_line(bReq), .attention_line(bAtn), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .hostIrq(hostIrq), .instrDone(instrDone),
		.haltReq(haltReq), .phaseReserved(bRes));
	task automatic check(input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		{regWr, regRd, regAddr, regWrData} <= {w, !w, a, d};
		@(posedge clk_sys);
		{regWr, regRd} <= 2'h0;
		@(negedge clk_sys);
	endtask
	function automatic logic [31:0] iw(input logic [2:0] p, input logic [5:0] f,
		input logic [7:0] m, d);
		return {5'h13, p, 2'h0, f, m, d};
	endfunction
	task automatic run(input logic [31:0] w, input logic act);
		repeat (3) @(posedge clk_sys);
		{instrWord, instrValid} <= {w, 1'b1};
		@(posedge clk_sys);
		instrValid <= 1'b0;
		for (lat = 0; instrDone !== 1'b1 && lat < 40; lat++) @(negedge clk_sys);
		check({instrDone, haltReq}, {1'b1, act & ~w[20]});
		acc(1'b0, 4'h2, 32'h0);
		check({regRdData[0], hostIrq}, {act, act & en});
		acc(1'b1, 4'h2, 32'h1);
		@(negedge clk_sys);
		check(hostIrq, 32'h0);
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		acc(1'b1, 4'h3, 32'h1);
		for (i = 0; i < 8; i++) begin
			ph <= i[2:0];
			run(iw(3'h2, 6'h12, 8'h00, 8'h00), i != 2);
			check(bRes, i == 4 || i == 5);
		end
		$display("phase tests done");
		last_byte_reg <= 8'hFB;
		run(iw(3'h0, 6'h1C, 8'h07, 8'hF8), 1'b1);
		last_byte_reg <= 8'h7B;
		run(iw(3'h0, 6'h1C, 8'h07, 8'hF8), 1'b0);
		aluCarry <= 1'b1;
		run(iw(3'h0, 6'h38, 8'h00, 8'h00), 1'b1);
		initiatorMode <= 1'b0;
		run(iw(3'h0, 6'h1A, 8'h00, 8'h00), 1'b0);
		atn <= 1'b1;
		run(iw(3'h0, 6'h1A, 8'h00, 8'h00), 1'b1);
		{initiatorMode, reqDly, ph} <= {1'b1, 4'hC, 3'h2};
		run(iw(3'h2, 6'h1B, 8'h00, 8'h00), 1'b1);
		check(lat > 4, 32'h1);
		reqDly <= 4'h0;
		run(iw(3'h0, 6'h08, 8'h00, 8'h00), 1'b1);
		acc(1'b0, 4'h1, 32'h0);
		check(regRdData, 32'hC0DE0001);
		@(posedge clk_sys);
		{fetchWrite, fetchWord} <= {1'b1, 32'h0BADF00D};
		@(posedge clk_sys);
		fetchWrite <= 1'b0;
		acc(1'b0, 4'h1, 32'h0);
		check(regRdData, 32'h0BADF00D);
		acc(1'b0, 4'h9, 32'h0);
		check(regRdData, 32'h0);
		en <= 1'b0;
		acc(1'b1, 4'h3, 32'h0);
		run(iw(3'h0, 6'h18, 8'h00, 8'h00), 1'b1);
		$display("control tests done");
		final_report;
	end
	initial begin
		#500000;
		error_cnt++;
		final_report;
	end
endmodule // interrupt_on_fly_exec_tb_top
`default_nettype wire

// ### verilog/ifx_consts.vh
// constants for the interrupt-no-halt instruction executor
// assumes inclusion by bare name from verilog/ files
`ifndef IFX_CONSTS_VH
`define IFX_CONSTS_VH
`define IFX_TYPE_HI      31
`define IFX_TYPE_LO      30
`define IFX_TYPE_XFER    2'h2
`define IFX_OPC_HI       29
`define IFX_OPC_LO       27
`define IFX_OPC_INT      3'h3
`define IFX_PHASE_HI     26
`define IFX_PHASE_LO     24
`define IFX_BIT_CARRY    21
`define IFX_BIT_NOHALT   20
`define IFX_BIT_TRUE     19
`define IFX_BIT_CDATA    18
`define IFX_BIT_CPHASE   17
`define IFX_BIT_WAIT     16
`define IFX_MASK_HI      15
`define IFX_MASK_LO      8
`define IFX_DATA_HI      7
`define IFX_DATA_LO      0
`define IFX_PH_DOUT      3'h0
`define IFX_PH_DIN       3'h1
`define IFX_PH_CMD       3'h2
`define IFX_PH_STAT      3'h3
`define IFX_PH_RES4      3'h4
`define IFX_PH_RES5      3'h5
`define IFX_PH_MOUT      3'h6
`define IFX_PH_MIN       3'h7
`define IFX_ADDR_CMD     4'h0
`define IFX_ADDR_PTR     4'h1
`define IFX_ADDR_STAT    4'h2
`define IFX_ADDR_CTRL    4'h3
`define IFX_ST_IDLE      2'h0
`define IFX_ST_WAIT      2'h1
`define IFX_ST_EVAL      2'h2
`define IFX_ST_DONE      2'h3
`endif

// ### verilog/ifx_interrupt_no_halt_exec.v
// executor of the interrupt-no-halt transfer control instruction
// assumes bus lines arrive asynchronous from pins, the rest on clk_sys
// Functional notes
// - wait qualifier holds evaluation until the bus request line is active
// - negation clears the true-sense bit, otherwise it is set
// - phase test compares msg, c/d, i/o lines; initiator mode only
// - attention test uses the initiator attention line; target mode only
// - carry test takes the outcome from the alu carry flag alone
// - phase codes 0..7 decode; codes 4 and 5 reserved unless dual-transition
// - transfer phases need select negated and busy asserted
// - no-halt flag set: true condition interrupts, processor keeps running
// - true-sense 0 acts on a false condition, 1 on a true one
// - compare-data bit enables data byte comparison against received byte
// - compare-phase bit enables phase or attention comparison
// - wait bit 0 compares at once, 1 waits for target request
// - set mask bits exclude last-byte positions from the data compare
// - data field checked for equality against the masked byte
// - interrupt value goes to pointer-save, overwritten by next fetch
// - match sets the status flag and raises the host interrupt request
// - no match: no interrupt, next instruction fetched
// - data compare uses the last-byte register contents
`timescale 1ns/10ps
`default_nettype none
`include "ifx_consts.vh"
module ifx_interrupt_no_halt_exec #(
	parameter DUAL_XFER = 1'b0
) (
	// clock and reset
	input  wire        clk_sys,
	input  wire        rst,
	// instruction issue from the fetch unit
	input  wire        instrValid,
	input  wire [31:0] instrWord,
	input  wire [31:0] instrValue,
	// processor state
	input  wire        initiatorMode,
	input  wire        aluCarry,
	input  wire [7:0]  last_byte_reg,
	input  wire        fetchWrite,
	input  wire [31:0] fetchWord,
	// bus lines, active high, asynchronous
	input  wire        busMsg,
	input  wire        busCd,
	input  wire        busIo,
	input  wire        busSel,
	input  wire        busBsy,
	input  wire        bus_request_line,
	input  wire        attention_line,
	// register port
	input  wire [3:0]  regAddr,
	input  wire [31:0] regWrData,
	input  wire        regWr,
	input  wire        regRd,
	output reg  [31:0] regRdData,
	// results
	output reg         hostIrq,
	output reg         instrDone,
	output reg         haltReq,
	output reg         phaseReserved
);
	reg  [1:0]  state;
	reg  [1:0]  next_state;
	reg  [31:0] command_byte_reg;
	reg  [31:0] pointer_save_reg;
	reg         interrupt_status_reg;
	reg         irqEnable;
	reg  [6:0]  syncA;
	reg  [6:0]  syncB;
	wire        reqS  = syncB[0];
	wire        atnS  = syncB[1];
	wire [2:0]  phS   = syncB[4:2];
	wire        selS  = syncB[5];
	wire        bsyS  = syncB[6];
	// field decode
	wire isOp = (instrWord[`IFX_TYPE_HI:`IFX_TYPE_LO] == `IFX_TYPE_XFER) &&
		(instrWord[`IFX_OPC_HI:`IFX_OPC_LO] == `IFX_OPC_INT);
	wire [2:0] fPhase = command_byte_reg[`IFX_PHASE_HI:`IFX_PHASE_LO];
	wire fCarry  = command_byte_reg[`IFX_BIT_CARRY];
	wire fNoHalt = command_byte_reg[`IFX_BIT_NOHALT];
	wire fTrue   = command_byte_reg[`IFX_BIT_TRUE];
	wire fCData  = command_byte_reg[`IFX_BIT_CDATA];
	wire fCPhase = command_byte_reg[`IFX_BIT_CPHASE];
	wire fWait   = command_byte_reg[`IFX_BIT_WAIT];
	wire [7:0] fMask = command_byte_reg[`IFX_MASK_HI:`IFX_MASK_LO];
	wire [7:0] fData = command_byte_reg[`IFX_DATA_HI:`IFX_DATA_LO];
	// condition evaluation
	wire xferPhase = ~selS & bsyS;
	wire phaseHit  = initiatorMode ? (xferPhase && (phS == fPhase))
		: atnS;
	wire dataHit   = ((last_byte_reg | fMask) == (fData | fMask));
	wire cond      = fCarry ? aluCarry :
		((~fCPhase | phaseHit) & (~fCData | dataHit));
	wire act       = (cond == fTrue);
	wire resvCode  = ~DUAL_XFER &&
		((phS == `IFX_PH_RES4) || (phS == `IFX_PH_RES5));
	// synchronise bus lines
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			syncA <= 7'h00;
			syncB <= 7'h00;
		end else begin
			syncA <= {busBsy, busSel, busMsg, busCd, busIo,
				attention_line, bus_request_line};
			syncB <= syncA;
		end
	end
	// sequencer
	always @* begin
		next_state = state;
		case (state)
		`IFX_ST_IDLE: begin
			if (instrValid && isOp)
				next_state = instrWord[`IFX_BIT_WAIT] ? `IFX_ST_WAIT
					: `IFX_ST_EVAL;
		end
		`IFX_ST_WAIT: begin
			if (reqS)
				next_state = `IFX_ST_EVAL;
		end
		`IFX_ST_EVAL: next_state = `IFX_ST_DONE;
		`IFX_ST_DONE: next_state = `IFX_ST_IDLE;
		default: next_state = `IFX_ST_IDLE;
		endcase
	end
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state <= `IFX_ST_IDLE;
			command_byte_reg <= 32'h00000000;
			pointer_save_reg <= 32'h00000000;
			interrupt_status_reg <= 1'b0;
			irqEnable <= 1'b0;
			hostIrq <= 1'b0;
			instrDone <= 1'b0;
			haltReq <= 1'b0;
			phaseReserved <= 1'b0;
			regRdData <= 32'h00000000;
		end else begin
			state <= next_state;
			instrDone <= 1'b0;
			haltReq <= 1'b0;
			if (state == `IFX_ST_IDLE && instrValid && isOp) begin
				command_byte_reg <= instrWord;
				pointer_save_reg <= instrValue;
			end else if (fetchWrite) begin
				pointer_save_reg <= fetchWord;
			end
			if (state == `IFX_ST_EVAL) begin
				instrDone <= 1'b1;
				haltReq <= act & ~fNoHalt;
				phaseReserved <= fCPhase & resvCode;
			end
			// set wins over software clear
			if (state == `IFX_ST_EVAL && act)
				interrupt_status_reg <= 1'b1;
			else if (regWr && regAddr == `IFX_ADDR_STAT && regWrData[0])
				interrupt_status_reg <= 1'b0;
			if (regWr && regAddr == `IFX_ADDR_CTRL)
				irqEnable <= regWrData[0];
			hostIrq <= irqEnable & (interrupt_status_reg |
				(state == `IFX_ST_EVAL && act));
			if (regRd) begin
				case (regAddr)
				`IFX_ADDR_CMD:  regRdData <= command_byte_reg;
				`IFX_ADDR_PTR:  regRdData <= pointer_save_reg;
				`IFX_ADDR_STAT: regRdData <= {30'h00000000,
					state != `IFX_ST_IDLE, interrupt_status_reg};
				`IFX_ADDR_CTRL: regRdData <= {31'h00000000, irqEnable};
				default:        regRdData <= 32'h00000000;
				endcase
			end else begin
				regRdData <= 32'h00000000;
			end
		end
	end
endmodule // ifx_interrupt_no_halt_exec
`default_nettype wire
